// ---- fip_port_control.sv ----
// Fast infrared port control: enables, loopback, underrun action, requests
`default_nettype none
`timescale 1ns/1ps

module fip_port_control #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ctlWrEn,
  input  wire logic [fip_pkg::CTL_WIDTH-1:0] ctlWrData,
  output logic [fip_pkg::CTL_WIDTH-1:0]      ctlRdData,
  input  wire logic                          txWrValid,
  output logic                               txWrReady,
  input  wire logic [7:0]                    txWrData,
  output logic                               rxRdValid,
  input  wire logic                          rxRdReady,
  output logic [7:0]                         rxRdData,
  input  wire logic                          underrunClr,
  output logic                               txUnderrunFlag,
  output logic                               txBusy,
  output logic                               txDmaReq,
  output logic                               rxDmaReq,
  output logic                               txServiceIrq,
  output logic                               rxServiceIrq,
  output logic                               txUnderrunIrq,
  output logic                               irTransmitPinOut,
  output logic                               irTransmitPinOe,
  input  wire logic                          irReceivePin,
  output logic                               irReceiveOwned
);
  import fip_pkg::*;

  localparam int CNTW = $clog2(BUF_DEPTH + 1);

  // Buffer depth is served by the buffer's own check; keep it sane here
  if (BUF_DEPTH < 2) begin : g_bad_depth
    $error("fip_port_control BUF_DEPTH must be at least 2");
  end

  // Control register and decoded fields
  logic [CTL_WIDTH-1:0] ctl_ff;         // Port control word
  wire  rateSel  = ctl_ff[CTL_RATE_BIT]; // High-speed engine selected
  wire  loopSel  = ctl_ff[CTL_LOOP_BIT]; // Internal loop select
  wire  uactSel  = ctl_ff[CTL_UACT_BIT]; // Underrun action select
  wire  txEnBit  = ctl_ff[CTL_TXE_BIT];  // Transmit enable bit
  wire  rxEnBit  = ctl_ff[CTL_RXE_BIT];  // Receive enable bit
  wire  rieSel   = ctl_ff[CTL_RIE_BIT];  // Rx service irq enable
  wire  tieSel   = ctl_ff[CTL_TIE_BIT];  // Tx service irq enable

  // Enables only count while the high-speed engine is chosen
  wire  txEnEff  = txEnBit & rateSel;
  wire  rxEnEff  = rxEnBit & rateSel;

  // Register write; reset leaves the port disabled
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_ff <= CTL_RESET;
    end else if (ctlWrEn) begin
      ctl_ff <= ctlWrData;
    end
  end

  assign ctlRdData = ctl_ff;

  // Transmit side state
  fip_tx_state_e state_ff;       // Sequencer state
  fip_tx_state_e nxtState;       // Next sequencer state
  logic [7:0]    shift_ff;       // Output shifter, MSB first
  logic [7:0]    nxtShift;       // Next shifter value
  logic [2:0]    bitCnt_ff;      // Bit within current unit
  logic [7:0]    guardCnt_ff;    // Guard pulse length count
  logic [4:0]    preamCnt_ff;    // Preambles already sent
  logic [7:0]    crc_ff;         // Running frame check value
  logic          abortSip_ff;    // Guard belongs to an abort
  logic          txBit_ff;       // Serial bit toward the pin
  logic          txEnPrev_ff;    // Enable seen last cycle
  logic          underrun_ff;    // Sticky underrun flag
  logic          txOutValid;     // Buffer holds a byte
  logic [7:0]    txOutData;      // Oldest buffered byte
  logic          txInReady;      // Buffer has room
  logic [CNTW-1:0] txCount;      // Buffer fill

  // Edge of the effective enable launches the guard pulse
  wire txRise = txEnEff & ~txEnPrev_ff;

  // Sequencer decode terms
  wire unitEnd    = (bitCnt_ff == UNIT_LAST);
  wire guardEnd   = (guardCnt_ff == GUARD_LAST);
  wire preamDone  = (preamCnt_ff >= PREAM_LAST);
  wire inIdle     = (state_ff == TX_IDLE);
  wire inGuard    = (state_ff == TX_GUARD);
  wire inData     = (state_ff == TX_DATA);
  wire inPream    = (state_ff == TX_PREAM);
  wire idleStart  = inIdle & ~txRise & txOutValid;
  wire dataNext   = inData & unitEnd & txOutValid;
  wire underrunHit = inData & unitEnd & ~txOutValid;
  wire preamExit  = inPream & unitEnd & preamDone & txOutValid;
  wire popNow     = txEnEff & (idleStart | dataNext | preamExit);

  // Bit-serial frame check update on the bit now leaving
  wire       crcFb  = crc_ff[7] ^ shift_ff[7];
  wire [7:0] crcUpd = {crc_ff[6:0], 1'b0} ^ (crcFb ? CRC_POLY : 8'h00);

  // Writes are refused while the transmitter is off
  assign txWrReady = txInReady & txEnEff;

  // Transmit buffer, flushed whenever the transmitter is off
  fip_buffer #(
    .WIDTH    (8),
    .DEPTH    (BUF_DEPTH)
  ) u_tx_buf (
    .clk      (clk),
    .srst     (srst),
    .flush    (~txEnEff),
    .inValid  (txWrValid & txEnEff),
    .inReady  (txInReady),
    .inData   (txWrData),
    .outValid (txOutValid),
    .outReady (popNow),
    .outData  (txOutData),
    .count    (txCount)
  );

  // Next state of the transmit sequencer
  always_comb begin
    nxtState = state_ff;
    case (state_ff)
      TX_IDLE: begin
        if (txRise) begin
          nxtState = TX_GUARD;
        end else if (txOutValid) begin
          nxtState = TX_DATA;
        end
      end
      TX_GUARD: begin
        if (guardEnd) begin
          nxtState = abortSip_ff ? TX_PREAM : TX_IDLE;
        end
      end
      TX_DATA: begin
        if (underrunHit) begin
          nxtState = uactSel ? TX_ABORT : TX_CRC;
        end
      end
      TX_CRC: begin
        if (unitEnd) begin
          nxtState = TX_STOP;
        end
      end
      TX_STOP: begin
        if (unitEnd) begin
          nxtState = TX_GUARD;
        end
      end
      TX_ABORT: begin
        if (unitEnd) begin
          nxtState = TX_GUARD;
        end
      end
      TX_PREAM: begin
        if (preamExit) begin
          nxtState = TX_DATA;
        end
      end
      default: begin
        nxtState = TX_IDLE;
      end
    endcase
    // Disabling stops any transfer at the next edge
    if (!txEnEff) begin
      nxtState = TX_IDLE;
    end
  end

  // Next shifter contents: load a unit or shift one bit out
  always_comb begin
    nxtShift = {shift_ff[6:0], 1'b0};
    if (popNow) begin
      nxtShift = txOutData;
    end else if (underrunHit && !uactSel) begin
      nxtShift = crcUpd;
    end else if (underrunHit && uactSel) begin
      nxtShift = ABORT_PATTERN;
    end else if (state_ff == TX_CRC && unitEnd) begin
      nxtShift = STOP_PATTERN;
    end else if (inPream && unitEnd) begin
      nxtShift = PREAM_PATTERN;
    end else if (inGuard && guardEnd && abortSip_ff) begin
      nxtShift = PREAM_PATTERN;
    end
    if (!txEnEff) begin
      nxtShift = 8'h00;
    end
  end

  // Sequencer state and shifter
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= TX_IDLE;
      shift_ff <= 8'h00;
    end else begin
      state_ff <= nxtState;
      shift_ff <= nxtShift;
    end
  end

  // Bit and guard counters; both rest at zero outside their states
  always_ff @(posedge clk) begin
    if (srst || inIdle || inGuard || !txEnEff) begin
      bitCnt_ff <= 3'h0;
    end else begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !inGuard || !txEnEff) begin
      guardCnt_ff <= 8'h00;
    end else begin
      guardCnt_ff <= guardCnt_ff + 8'h01;
    end
  end

  // Preamble count saturates once the minimum is reached
  always_ff @(posedge clk) begin
    if (srst || !inPream) begin
      preamCnt_ff <= 5'h00;
    end else if (unitEnd && !preamDone) begin
      preamCnt_ff <= preamCnt_ff + 5'h01;
    end
  end

  // Frame check runs on data only and restarts between frames
  always_ff @(posedge clk) begin
    if (srst || inIdle || inGuard || inPream) begin
      crc_ff <= CRC_INIT;
    end else if (inData) begin
      crc_ff <= crcUpd;
    end
  end

  // Remember that the coming guard pulse ends an abort
  always_ff @(posedge clk) begin
    if (srst || !txEnEff) begin
      abortSip_ff <= 1'b0;
    end else if (underrunHit && uactSel) begin
      abortSip_ff <= 1'b1;
    end else if (inGuard && guardEnd) begin
      abortSip_ff <= 1'b0;
    end
  end

  // Serial bit: guard drives high, units shift out, idle is low
  always_ff @(posedge clk) begin
    if (srst || !txEnEff) begin
      txBit_ff <= 1'b0;
    end else if (inGuard) begin
      txBit_ff <= 1'b1;
    end else if (inIdle) begin
      txBit_ff <= 1'b0;
    end else begin
      txBit_ff <= shift_ff[7];
    end
  end

  // Enable history for the edge detector
  always_ff @(posedge clk) begin
    if (srst) begin
      txEnPrev_ff <= 1'b0;
    end else begin
      txEnPrev_ff <= txEnEff;
    end
  end

  // Sticky underrun flag; a new underrun beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      underrun_ff <= 1'b0;
    end else if (underrunHit) begin
      underrun_ff <= 1'b1;
    end else if (underrunClr) begin
      underrun_ff <= 1'b0;
    end
  end

  assign txUnderrunFlag = underrun_ff;
  assign txBusy         = ~inIdle;

  // Pin ownership: the port drives only when enabled and not looped
  assign irTransmitPinOe  = txEnEff & ~loopSel;
  assign irTransmitPinOut = txBit_ff;
  assign irReceiveOwned   = rxEnEff & ~loopSel;

  // Receive side: pin synchroniser, three stages
  logic       rxSync1_ff;   // First stage, read by stage two only
  logic       rxSync2_ff;   // Second stage
  logic       rxSync3_ff;   // Third stage
  logic       rxLevel_ff;   // Settled pin level
  logic       rxActive_ff;  // Collecting a unit
  logic [7:0] rxShift_ff;   // Input shifter
  logic [2:0] rxCnt_ff;     // Bits collected
  logic       rxPush_ff;    // Completed unit offered to buffer
  logic       rxInReady;    // Receive buffer has room
  logic [CNTW-1:0] rxCount; // Receive buffer fill

  always_ff @(posedge clk) begin
    if (srst) begin
      rxSync1_ff <= 1'b0;
      rxSync2_ff <= 1'b0;
      rxSync3_ff <= 1'b0;
    end else begin
      rxSync1_ff <= irReceivePin;
      rxSync2_ff <= rxSync1_ff;
      rxSync3_ff <= rxSync2_ff;
    end
  end

  // Level changes once the last two stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      rxLevel_ff <= 1'b0;
    end else if (rxSync2_ff == rxSync3_ff) begin
      rxLevel_ff <= rxSync3_ff;
    end
  end

  // Loopback takes the transmit bit instead of the pin
  wire rxSerial = loopSel ? txBit_ff : rxLevel_ff;

  // Receive collector; runs regardless of transmit activity
  always_ff @(posedge clk) begin
    if (srst || !rxEnEff) begin
      rxActive_ff <= 1'b0;
      rxShift_ff  <= 8'h00;
      rxCnt_ff    <= 3'h0;
      rxPush_ff   <= 1'b0;
    end else if (!rxActive_ff) begin
      rxActive_ff <= rxSerial;
      rxCnt_ff    <= 3'h0;
      rxPush_ff   <= 1'b0;
    end else begin
      rxShift_ff  <= {rxShift_ff[6:0], rxSerial};
      rxCnt_ff    <= rxCnt_ff + 3'h1;
      rxActive_ff <= (rxCnt_ff != UNIT_LAST);
      rxPush_ff   <= (rxCnt_ff == UNIT_LAST);
    end
  end

  // Receive buffer, flushed whenever the receiver is off
  fip_buffer #(
    .WIDTH    (8),
    .DEPTH    (BUF_DEPTH)
  ) u_rx_buf (
    .clk      (clk),
    .srst     (srst),
    .flush    (~rxEnEff),
    .inValid  (rxPush_ff),
    .inReady  (rxInReady),
    .inData   (rxShift_ff),
    .outValid (rxRdValid),
    .outReady (rxRdReady),
    .outData  (rxRdData),
    .count    (rxCount)
  );

  // Service flags, requests and gated interrupts
  wire rxServiceFlag = rxEnEff & (rxCount != '0);
  wire txServiceFlag = txEnEff & (txCount <= CNTW'(BUF_DEPTH / 2));

  assign rxDmaReq      = rxServiceFlag;
  assign txDmaReq      = txServiceFlag;
  assign rxServiceIrq  = rieSel & rxServiceFlag;
  assign txServiceIrq  = tieSel & txServiceFlag;
  assign txUnderrunIrq = uactSel & underrun_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence endOfFrame;
    (state_ff == TX_CRC)[*8] ##1 (state_ff == TX_STOP)[*8]
      ##1 (state_ff == TX_GUARD);
  endsequence

  sequence abortRun;
    (state_ff == TX_ABORT)[*8] ##1 (state_ff == TX_GUARD)[*4]
      ##1 (state_ff == TX_PREAM)[*8];
  endsequence

  chk_loop_pins: assert property (
    loopSel |-> !irTransmitPinOe && !irReceiveOwned)
    else $error("pins still owned in loopback");

  chk_normal_pins: assert property (
    txEnEff && !loopSel |-> irTransmitPinOe)
    else $error("transmit pin not owned while enabled");

  chk_rate_ignore: assert property (
    !rateSel |-> !irTransmitPinOe && !irReceiveOwned && !txBusy)
    else $error("port active with low-speed rate");

  chk_guard_first: assert property (
    txRise |=> (state_ff == TX_GUARD) ##1 irTransmitPinOut)
    else $error("no guard pulse after enable");

  chk_tx_stop: assert property (
    !txEnEff |=> state_ff == TX_IDLE && txCount == '0
      && shift_ff == 8'h00 && !irTransmitPinOut)
    else $error("transmitter not stopped and flushed");

  chk_rx_flush: assert property (
    !rxEnEff |=> !rxActive_ff && rxCount == '0 && !rxRdValid)
    else $error("receiver not stopped and flushed");

  chk_frame_end: assert property (
    @(posedge clk) disable iff (srst || !txEnEff)
    underrunHit && !uactSel |=> endOfFrame)
    else $error("frame end sequence wrong");

  chk_abort_run: assert property (
    @(posedge clk) disable iff (srst || !txEnEff)
    underrunHit && uactSel |=> abortRun)
    else $error("abort sequence wrong");

  chk_pream_min: assert property (
    preamExit |-> preamCnt_ff == PREAM_LAST)
    else $error("preambles ended before minimum");

  chk_uflow_irq: assert property (
    underrunHit && !underrunClr |=> txUnderrunFlag
      && (txUnderrunIrq == uactSel))
    else $error("underrun flag or interrupt wrong");

  chk_svc_gate: assert property (
    (rxServiceIrq |-> rieSel && rxDmaReq)
      and (txServiceIrq |-> tieSel && txDmaReq))
    else $error("service interrupt not gated");
endmodule // fip_port_control

`default_nettype wire

// ---- fip_buffer.sv ----
// Shared constants for the fast infrared port and its buffer, two entries deep by default
`default_nettype none

package fip_pkg;
  // Control register layout
  localparam int          CTL_WIDTH     = 8;
  localparam int          CTL_RATE_BIT  = 0;  // Rate select
  localparam int          CTL_LOOP_BIT  = 1;  // Internal loop select
  localparam int          CTL_UACT_BIT  = 2;  // Underrun action select
  localparam int          CTL_TXE_BIT   = 3;  // Transmit enable bit
  localparam int          CTL_RXE_BIT   = 4;  // Receive enable bit
  localparam int          CTL_RIE_BIT   = 5;  // Rx service irq enable
  localparam int          CTL_TIE_BIT   = 6;  // Tx service irq enable
  localparam int          CTL_AME_BIT   = 7;  // Address match enable
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  // Serial unit framing
  localparam int          UNIT_BITS     = 8;
  localparam logic [2:0]  UNIT_LAST     = 3'h7;
  localparam int          CHIP_BITS     = 4;
  localparam int          ABORT_CHIPS   = 2;
  localparam logic [7:0]  ABORT_PATTERN = 8'h00;
  localparam logic [7:0]  STOP_PATTERN  = 8'h7E;
  localparam logic [7:0]  PREAM_PATTERN = 8'hA5;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [4:0]  PREAM_LAST    = 5'h0F;  // 16 preambles minimum
  // Guard pulse timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          GUARD_TIME_NS = 200;
  localparam int          GUARD_CYCLES  =
    (GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  GUARD_LAST    = 8'(GUARD_CYCLES - 1);
  // Transmit sequencer states, Gray in the order listed
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_GUARD = 3'h1,
    TX_DATA  = 3'h3,
    TX_CRC   = 3'h2,
    TX_STOP  = 3'h6,
    TX_ABORT = 3'h7,
    TX_PREAM = 3'h5
  } fip_tx_state_e;
endpackage

`timescale 1ns/1ps

module fip_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       flush,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [WIDTH-1:0]                outData,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int PTRW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNTW = $clog2(DEPTH + 1);

  // Depth must be a power of two so pointers wrap naturally
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fip_buffer DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Entry storage
  logic [PTRW-1:0]  wrPtr_ff;        // Next entry to fill
  logic [PTRW-1:0]  rdPtr_ff;        // Oldest entry
  logic [CNTW-1:0]  count_ff;        // Entries held

  wire push = inValid & inReady;
  wire pop  = outValid & outReady;

  assign inReady  = (count_ff != CNTW'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign count    = count_ff;

  // One storage word per entry, written when the pointer selects it
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && wrPtr_ff == PTRW'(i)) begin
        mem_ff[i] <= inData;
      end
    end
  end

  // Pointers and fill count; a flush empties at once
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= push ? wrPtr_ff + PTRW'(1) : wrPtr_ff;
      rdPtr_ff <= pop ? rdPtr_ff + PTRW'(1) : rdPtr_ff;
      count_ff <= count_ff + CNTW'(push) - CNTW'(pop);
    end
  end
endmodule // fip_buffer

`default_nettype wire

// ---- fip_ir_partner.sv ----
// Infrared transceiver model that sends bytes towards the receive pin
`timescale 1ns/1ps
`default_nettype none

module fip_ir_partner (
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [7:0] sendByte,
  output logic            irReceivePin
);
  logic [8:0] frame_ff = 9'h000;  // Start mark then byte, MSB first
  logic [3:0] left_ff  = 4'h0;    // Bits still to send

  // One bit per clock; the line stays dark between frames
  always_ff @(posedge clk) begin
    if (send) begin
      frame_ff <= {1'b1, sendByte};
      left_ff  <= 4'h9;
    end else if (left_ff != 4'h0) begin
      frame_ff <= {frame_ff[7:0], 1'b0};
      left_ff  <= left_ff - 4'h1;
    end
  end

  // Dark line reads as zero at the receiver
  assign irReceivePin = (left_ff != 4'h0) ? frame_ff[8] : 1'b0;
endmodule  // fip_ir_partner

`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the fast infrared port control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import fip_pkg::*;
  logic       clk, srst, ctlWrEn, txWrValid, rxRdReady, underrunClr;
  logic       txWrReady, rxRdValid, txUnderrunFlag, txBusy, txDmaReq;
  logic       rxDmaReq, txServiceIrq, rxServiceIrq, txUnderrunIrq, send;
  logic       irTransmitPinOut, irTransmitPinOe, irReceivePin;
  logic       irReceiveOwned;
  logic [7:0] ctlWrData, ctlRdData, txWrData, rxRdData, sendByte;
  int         fail_count, checks, n;

  fip_port_control #(.BUF_DEPTH(2)) i_fip_port_control (
    .clk(clk), .srst(srst), .ctlWrEn(ctlWrEn), .ctlWrData(ctlWrData),
    .ctlRdData(ctlRdData), .txWrValid(txWrValid), .txWrReady(txWrReady),
    .txWrData(txWrData), .rxRdValid(rxRdValid), .rxRdReady(rxRdReady),
    .rxRdData(rxRdData), .underrunClr(underrunClr),
    .txUnderrunFlag(txUnderrunFlag), .txBusy(txBusy),
    .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq),
    .txServiceIrq(txServiceIrq), .rxServiceIrq(rxServiceIrq),
    .txUnderrunIrq(txUnderrunIrq), .irTransmitPinOut(irTransmitPinOut),
    .irTransmitPinOe(irTransmitPinOe), .irReceivePin(irReceivePin),
    .irReceiveOwned(irReceiveOwned));

  fip_ir_partner i_fip_ir_partner (.clk(clk), .send(send),
    .sendByte(sendByte), .irReceivePin(irReceivePin));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Step past the next edge so its updates have landed
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Control register write, returns just after the taking edge
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    ctlWrEn   <= 1'b1;
    ctlWrData <= d;
    @(posedge clk);
    ctlWrEn   <= 1'b0;
    #1;
  endtask

  // Offer one transmit byte, hold it until taken
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    txWrValid <= 1'b1;
    txWrData  <= d;
    for (n = 0; n < 20; n++) begin
      #1;
      if (txWrReady === 1'b1) break;
      @(posedge clk);
    end
    if (n == 20) begin
      fail_count++;
      results();
    end
    @(posedge clk);
    txWrValid <= 1'b0;
  endtask

  // Bounded wait: 0 rx byte ready, 1 underrun flag, 2 transmitter idle
  task automatic waitSig(input int sel);
    logic hit;
    for (int i = 0; i < 300; i++) begin
      tick();
      hit = (sel == 0) ? rxRdValid : (sel == 1) ? txUnderrunFlag : !txBusy;
      if (hit === 1'b1) return;
    end
    fail_count++;
    results();
  endtask

  // One-cycle clear pulse for the sticky underrun flag
  task automatic clrUnder();
    @(posedge clk);
    underrunClr <= 1'b1;
    @(posedge clk);
    underrunClr <= 1'b0;
  endtask

  // Disabled after reset, control reads zero
  task automatic sReset();
    chk(ctlRdData, CTL_RESET);
    chk({irTransmitPinOe, irReceiveOwned, txWrReady, txBusy}, 8'h00);
  endtask

  // Enables have no effect while the low-speed engine is selected
  task automatic sRate();
    wr(8'h18);
    tick();
    chk({irTransmitPinOe, irReceiveOwned, txWrReady, txDmaReq},
      8'h00);
  endtask

  // Guard pulse on enabling, service request and its mask
  task automatic sGuard();
    wr(8'h41);
    wr(8'h49);
    n = 0;
    repeat (12) begin
      n += int'(irTransmitPinOut);
      tick();
    end
    chk(8'(n), 8'(GUARD_CYCLES));
    chk({irTransmitPinOe, txDmaReq, txServiceIrq}, 8'h07);
    wr(8'h09);
    tick();
    chk({txDmaReq, txServiceIrq}, 8'h02);
  endtask

  // Underrun ends the frame, then aborts with preambles, then disable
  task automatic sUnder();
    logic [23:0] serial;  // Data, check value and stop unit off the pin
    push(8'hA5);
    tick();
    repeat (24) begin
      tick();
      serial = {serial[22:0], irTransmitPinOut};
    end
    chk(serial[23:16], 8'hA5);
    chk(serial[15:8], 8'h81);
    chk(serial[7:0], STOP_PATTERN);
    waitSig(1);
    chk(txUnderrunIrq, 8'h00);
    waitSig(2);
    clrUnder();
    tick();
    chk(txUnderrunFlag, 8'h00);
    wr(8'h0D);
    push(8'h3C);
    waitSig(1);
    tick();
    chk(txUnderrunIrq, 8'h01);
    repeat (140) tick();
    chk(txBusy, 8'h01);
    clrUnder();
    push(8'h66);
    waitSig(1);
    chk(txUnderrunIrq, 8'h01);
    wr(8'h01);
    tick();
    chk({irTransmitPinOe, txBusy, txWrReady}, 8'h00);
  endtask

  // Loopback: pins released, transmit reaches receive, rx disable flushes
  task automatic sLoop();
    wr(8'h03);
    wr(8'h1B);
    tick();
    chk({irTransmitPinOe, irReceiveOwned}, 8'h00);
    waitSig(0);
    chk(rxRdData, 8'hE0);
    chk({rxDmaReq, rxServiceIrq}, 8'h02);
    wr(8'h3B);
    tick();
    chk(rxServiceIrq, 8'h01);
    wr(8'h2B);
    tick();
    chk({rxRdValid, rxDmaReq, rxServiceIrq}, 8'h00);
    wr(8'h01);
  endtask

  // Own pins, receive from the far side while transmitting
  task automatic sPartner();
    wr(8'h21);
    wr(8'h39);
    tick();
    chk({irTransmitPinOe, irReceiveOwned}, 8'h03);
    push(8'h81);
    @(posedge clk);
    send     <= 1'b1;
    sendByte <= 8'hC3;
    @(posedge clk);
    send     <= 1'b0;
    waitSig(0);
    chk(rxRdData, 8'hC3);
    @(posedge clk);
    rxRdReady <= 1'b1;
    @(posedge clk);
    rxRdReady <= 1'b0;
    tick();
    chk(rxRdValid, 8'h00);
  endtask

  // Main sequence
  initial begin
    fail_count  = 0;
    checks      = 0;
    srst        = 1'b1;
    ctlWrEn     = 1'b0;
    ctlWrData   = 8'h00;
    txWrValid   = 1'b0;
    txWrData    = 8'h00;
    rxRdReady   = 1'b0;
    underrunClr = 1'b0;
    send        = 1'b0;
    sendByte    = 8'h00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    tick();
    sReset();
    sRate();
    sGuard();
    sUnder();
    sLoop();
    sPartner();
    results();
  end
endmodule  // tb

`default_nettype wire
